// file: hw/pld_dual_register_macrocell.sv
/*
  Register side of ten output macrocells with two flip-flops each, the
  product-term array that clocks, resets and feeds them, preload, power-up
  clear and the security fuse. Configuration is written over AXI4-Lite.
  Assumes pins are asynchronous to clk and the partner keeps setup times.
*/
module pld_dual_register_macrocell (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [11:0] in_pins,
    input  wire logic [9:0]  io_in,
    output logic      [9:0]  io_out,
    output logic      [9:0]  io_oe_n,
    input  wire logic        preload_hv,
    input  wire logic        verify_mode,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [12:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [12:0] araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp
);
    logic [11:0] in_m_q, in_q;
    logic [9:0]  io_m_q, io_q;
    logic        pre_m_q, pre_q, ver_m_q, ver_q;
    logic        fuse_q;
    logic [9:0]  pol_q, comb_q, osel_q;
    logic [79:0] alloc_q;
    logic [41:0] pt_t_q [pld_pkg::NUM_PT];
    logic [41:0] pt_c_q [pld_pkg::NUM_PT];
    logic [19:0] q_q, q_d, clk_t_q;
    logic [7:0]  por_cnt_q;
    logic        por_busy;
    logic [41:0] lit;
    logic [210:0] pt;
    logic [19:0] sum, d, clk_t, rst_t, rise, cap, pl, plval;
    logic [9:0]  oe_t, comb_sum;
    logic        preset, sel;
    logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q, do_wr;
    logic [12:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, new_w;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [32:0] wr_cur, rd_cur;
    logic [9:0]  io_out_q, io_oe_n_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        return r;
    endfunction

    function automatic logic pt_hit(input logic [12:0] a);
        return a >= pld_pkg::PT_BASE && a < pld_pkg::PT_END && a[1:0] == 2'h0;
    endfunction

    function automatic logic [7:0] pt_idx(input logic [12:0] a);
        logic [12:0] o;
        o = a - pld_pkg::PT_BASE;
        return o[11:4];
    endfunction

    // unprogrammed masks keep both literals of every input, so the term is false
    function automatic logic pt_eval(input logic [41:0] t, input logic [41:0] c,
                                     input logic [41:0] l);
        return (&(~t | l)) & (&(~c | ~l));
    endfunction

    // counts outside four to eight are clamped
    function automatic logic [7:0] used_mask(input logic [3:0] c);
        logic [3:0] n;
        logic [8:0] m;
        n = (c < 4'(pld_pkg::PT_MIN)) ? 4'(pld_pkg::PT_MIN)
          : (c > 4'(pld_pkg::PT_PER_SUM)) ? 4'(pld_pkg::PT_PER_SUM) : c;
        m = (9'h001 << n) - 9'h001;
        return m[7:0];
    endfunction

    // {hit, word}; pattern words are visible here, blocking is done by the caller
    function automatic logic [32:0] word_at(input logic [12:0] a);
        logic [7:0] i;
        i = pt_idx(a);
        case (a)
            pld_pkg::CTRL_OFS:   return {1'b1, 31'h0, fuse_q};
            pld_pkg::STATUS_OFS: return {1'b1, 28'h0, pre_q, ver_q, fuse_q, por_busy};
            pld_pkg::STATE_OFS:  return {1'b1, 12'h0, q_q};
            pld_pkg::POL_OFS:    return {1'b1, 22'h0, pol_q};
            pld_pkg::COMB_OFS:   return {1'b1, 22'h0, comb_q};
            pld_pkg::OSEL_OFS:   return {1'b1, 22'h0, osel_q};
            pld_pkg::ALLOC0_OFS: return {1'b1, alloc_q[31:0]};
            pld_pkg::ALLOC1_OFS: return {1'b1, alloc_q[63:32]};
            pld_pkg::ALLOC2_OFS: return {1'b1, 16'h0, alloc_q[79:64]};
            default:
            begin
                if (!pt_hit(a))
                    return 33'h0;
                case (a[3:2])
                    2'h0:    return {1'b1, pt_t_q[i][31:0]};
                    2'h1:    return {1'b1, 22'h0, pt_t_q[i][41:32]};
                    2'h2:    return {1'b1, pt_c_q[i][31:0]};
                    default: return {1'b1, 22'h0, pt_c_q[i][41:32]};
                endcase
            end
        endcase
    endfunction

    // pins cross into clk through two flops each
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            in_m_q  <= 12'h000;
            in_q    <= 12'h000;
            io_m_q  <= 10'h000;
            io_q    <= 10'h000;
            pre_m_q <= 1'b0;
            pre_q   <= 1'b0;
            ver_m_q <= 1'b0;
            ver_q   <= 1'b0;
        end
        else
        begin
            in_m_q  <= in_pins;
            in_q    <= in_m_q;
            io_m_q  <= io_in;
            io_q    <= io_m_q;
            pre_m_q <= preload_hv;
            pre_q   <= pre_m_q;
            ver_m_q <= verify_mode;
            ver_q   <= ver_m_q;
        end
    end

    // bus slave: address and data taken in either order, one write at a time
    assign awready = !aw_hold_q && !bvalid_q;
    assign wready  = !w_hold_q && !bvalid_q;
    assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 13'h0000;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= pld_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (do_wr)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_cur[32] ? pld_pkg::RESP_OKAY : pld_pkg::RESP_SLVERR;
            end
            else if (bvalid_q && bready)
                bvalid_q <= 1'b0;
        end
    end

    always_comb
    begin
        wr_cur = word_at(awaddr_q);
        new_w  = merge(wr_cur[31:0], wdata_q, wstrb_q);
        rd_cur = word_at(araddr);
    end

    // a programmed fuse hides the pattern from readback at once
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= pld_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= (pt_hit(araddr) && fuse_q) ? 32'h0 : rd_cur[31:0];
            rresp_q  <= rd_cur[32] ? pld_pkg::RESP_OKAY : pld_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && rready)
            rvalid_q <= 1'b0;
    end

    // configuration; the fuse only clears on reset, standing in for erase
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            fuse_q  <= 1'b0;
            pol_q   <= pld_pkg::POL_RST;
            comb_q  <= pld_pkg::COMB_RST;
            osel_q  <= pld_pkg::OSEL_RST;
            alloc_q <= pld_pkg::ALLOC_RST;
        end
        else if (do_wr)
        begin
            case (awaddr_q)
                pld_pkg::CTRL_OFS:   fuse_q <= fuse_q | new_w[pld_pkg::CTRL_FUSE_BIT];
                pld_pkg::POL_OFS:    pol_q <= new_w[9:0];
                pld_pkg::COMB_OFS:   comb_q <= new_w[9:0];
                pld_pkg::OSEL_OFS:   osel_q <= new_w[9:0];
                pld_pkg::ALLOC0_OFS: alloc_q[31:0] <= new_w;
                pld_pkg::ALLOC1_OFS: alloc_q[63:32] <= new_w;
                pld_pkg::ALLOC2_OFS: alloc_q[79:64] <= new_w[15:0];
                default:             fuse_q <= fuse_q;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            for (int p = 0; p < pld_pkg::NUM_PT; p++)
            begin
                pt_t_q[p] <= pld_pkg::PT_MASK_RST;
                pt_c_q[p] <= pld_pkg::PT_MASK_RST;
            end
        end
        else if (do_wr && pt_hit(awaddr_q))
        begin
            case (awaddr_q[3:2])
                2'h0:    pt_t_q[pt_idx(awaddr_q)][31:0]  <= new_w;
                2'h1:    pt_t_q[pt_idx(awaddr_q)][41:32] <= new_w[9:0];
                2'h2:    pt_c_q[pt_idx(awaddr_q)][31:0]  <= new_w;
                default: pt_c_q[pt_idx(awaddr_q)][41:32] <= new_w[9:0];
            endcase
        end
    end

    // product terms and sum terms
    always_comb
    begin
        lit = {q_q, io_q, in_q};
        for (int p = 0; p < pld_pkg::NUM_PT; p++)
            pt[p] = pt_eval(pt_t_q[p], pt_c_q[p], lit);
        for (int s = 0; s < pld_pkg::NUM_REG; s++)
            sum[s] = |(pt[s*8 +: 8] & used_mask(alloc_q[4*s +: 4]));
        for (int r = 0; r < pld_pkg::NUM_REG; r++)
        begin
            clk_t[r] = pt[pld_pkg::PT_CLK_BASE + r];
            rst_t[r] = pt[pld_pkg::PT_RST_BASE + r];
        end
        for (int m = 0; m < pld_pkg::NUM_IO; m++)
        begin
            oe_t[m]     = pt[pld_pkg::PT_OE_BASE + m];
            comb_sum[m] = comb_q[m] ? (sum[2*m] | sum[2*m+1]) : sum[2*m];
            d[2*m]      = comb_sum[m];
            d[2*m+1]    = sum[2*m+1];
        end
        preset = pt[pld_pkg::PT_PRESET];
        sel    = in_q[pld_pkg::SEL_PIN];
    end

    // next register state; reset term beats preset, preload and capture
    always_comb
    begin
        rise = clk_t & ~clk_t_q;
        cap  = rise & ~rst_t & {20{~pre_q}};
        for (int r = 0; r < pld_pkg::NUM_REG; r++)
        begin
            pl[r]    = rise[r] & ~rst_t[r] & pre_q & ((r % 2 == 1) == sel);
            plval[r] = io_q[r/2];
        end
        q_d = q_q & ~(rst_t | cap | pl);
        q_d = q_d | (cap & (preset ? 20'hfffff : d));
        q_d = q_d | (pl & plval);
    end

    // power-up clear window; partner keeps clock sources still meanwhile
    assign por_busy = por_cnt_q != 8'h00;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            por_cnt_q <= 8'(pld_pkg::T_PR_CYC);
        else if (por_busy)
            por_cnt_q <= por_cnt_q - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn || por_busy)
            q_q <= 20'h00000;
        else
            q_q <= q_d;
    end

    // edge history runs through the clear so a held-high term gives no edge
    always_ff @(posedge clk)
    begin
        if (!rstn)
            clk_t_q <= 20'h00000;
        else
            clk_t_q <= clk_t;
    end

    // pins are inputs during preload; fused verify floats everything
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            io_out_q  <= 10'h000;
            io_oe_n_q <= 10'h3ff;
        end
        else
        begin
            for (int m = 0; m < pld_pkg::NUM_IO; m++)
            begin
                io_out_q[m]  <= (osel_q[m] ? comb_sum[m] : q_q[2*m]) ^ pol_q[m];
                io_oe_n_q[m] <= !oe_t[m] || pre_q || (fuse_q && ver_q);
            end
        end
    end

    assign io_out  = io_out_q;
    assign io_oe_n = io_oe_n_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence wr_pair_s;
        aw_hold_q && w_hold_q && !bvalid_q;
    endsequence

    sequence pol_clear_s;
        por_busy && osel_q == 10'h000 ##1 por_busy;
    endsequence

    por_clear_a: assert property (por_busy |-> q_q == 20'h00000)
        else $error("register not clear during power-up window");
    pol_out_a: assert property (pol_clear_s |-> io_out == $past(pol_q))
        else $error("cleared output not shaped by polarity");
    rst_prio_a: assert property (rst_t != 20'h0 && !por_busy |=>
        (q_q & $past(rst_t)) == 20'h00000)
        else $error("reset term did not clear register");
    preset_set_a: assert property (preset && !por_busy |=>
        (q_q & $past(cap)) == $past(cap))
        else $error("preset did not set clocked register");
    capture_d_a: assert property (!preset && !por_busy |=>
        (q_q & $past(cap)) == ($past(d) & $past(cap)))
        else $error("clock edge did not load sum term");
    preload_val_a: assert property (pre_q && !por_busy |=>
        (q_q & $past(pl)) == ($past(plval) & $past(pl)))
        else $error("preload did not force pin level");
    hold_state_a: assert property (!por_busy |=>
        ((q_q ^ $past(q_q)) & ~$past(rst_t | rise)) == 20'h00000)
        else $error("register changed without edge or reset");
    fuse_hiz_a: assert property (fuse_q && ver_q |=> io_oe_n == 10'h3ff)
        else $error("outputs driven in fused verify");
    fuse_keep_a: assert property (fuse_q |=> fuse_q [*4])
        else $error("security fuse cleared");
    bus_wr_a: assert property (wr_pair_s |=> bvalid && !aw_hold_q)
        else $error("write response missing");
endmodule // pld_dual_register_macrocell

// file: hw/pld_pkg.sv
/*
  Constants shared by the dual-register macrocell block: array geometry,
  product-term map, register offsets, reset values and timing counts.
  Assumes a 250 MHz clock and an AXI4-Lite register bus with 32-bit data.
*/
package pld_pkg;
    localparam int NUM_IN      = 12;
    localparam int NUM_IO      = 10;
    localparam int NUM_REG     = 20;
    localparam int NUM_LIT     = 42;
    localparam int PT_PER_SUM  = 8;
    localparam int PT_MIN      = 4;
    localparam int PT_CLK_BASE = 160;
    localparam int PT_RST_BASE = 180;
    localparam int PT_OE_BASE  = 200;
    localparam int PT_PRESET   = 210;
    localparam int NUM_PT      = 211;
    localparam int SEL_PIN     = 4;
    localparam int ADDR_W      = 13;
    localparam int PT_STRIDE   = 16;

    localparam logic [12:0] CTRL_OFS   = 13'h0000;
    localparam logic [12:0] STATUS_OFS = 13'h0004;
    localparam logic [12:0] STATE_OFS  = 13'h0008;
    localparam logic [12:0] POL_OFS    = 13'h000c;
    localparam logic [12:0] COMB_OFS   = 13'h0010;
    localparam logic [12:0] OSEL_OFS   = 13'h0014;
    localparam logic [12:0] ALLOC0_OFS = 13'h0018;
    localparam logic [12:0] ALLOC1_OFS = 13'h001c;
    localparam logic [12:0] ALLOC2_OFS = 13'h0020;
    localparam logic [12:0] PT_BASE    = 13'h1000;
    localparam logic [12:0] PT_END     = PT_BASE + 13'(NUM_PT * PT_STRIDE);

    localparam int CTRL_FUSE_BIT  = 0;
    localparam int ST_POR_BIT     = 0;
    localparam int ST_FUSE_BIT    = 1;
    localparam int ST_VERIFY_BIT  = 2;
    localparam int ST_PRELOAD_BIT = 3;

    localparam logic [79:0] ALLOC_RST   = {20{4'h8}};
    localparam logic [41:0] PT_MASK_RST = {42{1'b1}};
    localparam logic [9:0]  POL_RST     = 10'h000;
    localparam logic [9:0]  COMB_RST    = 10'h000;
    localparam logic [9:0]  OSEL_RST    = 10'h000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int CLK_PERIOD_NS = 4;
    localparam int T_PR_NS       = 600;
    localparam int T_PR_CYC      = (T_PR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: testbench/pin_partner.sv
/*
  Pin-side partner: system logic and programmer driving the dedicated
  inputs, the I/O pins, the preload high-voltage level and verify.
  Assumes the bench calls its tasks one at a time, clk at 250 MHz.
*/
module pin_partner (
    input  wire logic        clk,
    input  wire logic [9:0]  io_out,
    input  wire logic [9:0]  io_oe_n,
    output logic      [11:0] in_pins,
    output logic      [9:0]  io_in,
    output logic             preload_hv,
    output logic             verify_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] io_drv;
    // sources stay low through the power-up window: no clock-term edge
    initial
    begin
        in_pins     = 12'h000;
        io_drv      = 10'h000;
        preload_hv  = 1'b0;
        verify_mode = 1'b0;
    end
    // device wins a pin where it drives, our level elsewhere
    always_comb
    begin
        for (int i = 0; i < 10; i++)
            io_in[i] = (io_oe_n[i] === 1'b0) ? io_out[i] : io_drv[i];
    end
    task set_in(input int b, input logic v);
        @(posedge clk);
        in_pins[b] <= v;
    endtask
    task set_io(input logic [9:0] v);
        @(posedge clk);
        io_drv <= v;
    endtask
    task set_mode(input logic hv, input logic vf);
        @(posedge clk);
        preload_hv  <= hv;
        verify_mode <= vf;
    endtask
    // rise only after data and preset have settled; long for the syncs
    task pulse_clk(input int b);
        repeat (4) @(posedge clk);
        in_pins[b] <= 1'b1;
        repeat (6) @(posedge clk);
        in_pins[b] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule // pin_partner

// file: testbench/tb_top.sv
/*
  Self-checking bench for the dual-register macrocell block: register
  bus master, scenario tasks and verdict. Assumes pin_partner and pld_pkg.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [41:0] NONE = 42'h0;
    localparam logic [41:0] ALL  = pld_pkg::PT_MASK_RST;
    logic        clk, rstn, preload_hv, verify_mode;
    logic [11:0] in_pins;
    logic [9:0]  io_in, io_out, io_oe_n;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [12:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  awprot, arprot;
    logic [3:0]  wstrb;
    int          num_errors = 0;
    int          n_compared = 0;

    pld_dual_register_macrocell DUT (
        .clk(clk), .rstn(rstn), .in_pins(in_pins), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n), .preload_hv(preload_hv), .verify_mode(verify_mode),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );
    pin_partner pins (
        .clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .in_pins(in_pins),
        .io_in(io_in), .preload_hv(preload_hv), .verify_mode(verify_mode)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // at least twenty times the expected run of under a thousand cycles: a hang ends here
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask
    task automatic axi_write(input logic [12:0] a, input logic [31:0] d,
                             input logic [1:0] er = pld_pkg::RESP_OKAY,
                             input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        awprot  <= 3'h2;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end
        while (!(bvalid === 1'b1 && bready) && n < 200);
        check("bvalid", 32'h1, 32'(bvalid));
        bready <= 1'b0;
        check("bresp", 32'(er), 32'(bresp));
    endtask
    task automatic axi_read(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arprot  <= 3'h2;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end
        while (!(rvalid === 1'b1 && rready) && n < 200);
        check("rvalid", 32'h1, 32'(rvalid));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic read_chk(input string what, input logic [12:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(what, exp, d);
    endtask
    // all four mask words of one product term
    task automatic set_term(input int t, input logic [41:0] tm, input logic [41:0] cm);
        logic [12:0] a;
        a = pld_pkg::PT_BASE + 13'(t * pld_pkg::PT_STRIDE);
        axi_write(a, tm[31:0]);
        axi_write(a + 13'h4, 32'(tm[41:32]));
        axi_write(a + 13'h8, cm[31:0]);
        axi_write(a + 13'hc, 32'(cm[41:32]));
    endtask

    task automatic t_power_up();
        read_chk("status busy", pld_pkg::STATUS_OFS, 32'h1);
        repeat (pld_pkg::T_PR_CYC) @(posedge clk);
        read_chk("status idle", pld_pkg::STATUS_OFS, 32'h0);
        read_chk("state cleared", pld_pkg::STATE_OFS, 32'h0);
        read_chk("alloc reset", pld_pkg::ALLOC0_OFS, 32'h88888888);
        set_term(200, NONE, NONE);
        axi_write(pld_pkg::POL_OFS, 32'h1);
        settle();
        check("out after clear", 32'h1, 32'(io_out[0]));
        check("oe_n own term", 32'h0, 32'(io_oe_n[0]));
        axi_write(pld_pkg::POL_OFS, 32'h0);
        axi_write(pld_pkg::POL_OFS, 32'h3ff, pld_pkg::RESP_OKAY, 4'h2);
        read_chk("pol byte lane", pld_pkg::POL_OFS, 32'h300);
        axi_write(pld_pkg::POL_OFS, 32'h0);
    endtask
    task automatic t_clock_sum();
        set_term(0, NONE, NONE);
        set_term(160, 42'h1, NONE);
        pins.pulse_clk(0);
        read_chk("state own clock", pld_pkg::STATE_OFS, 32'h1);
        check("out follows reg", 32'h1, 32'(io_out[0]));
    endtask
    task automatic t_comb_alloc();
        set_term(0, ALL, ALL);
        set_term(12, NONE, NONE);
        set_term(161, 42'h1, NONE);
        pins.pulse_clk(0);
        read_chk("state split", pld_pkg::STATE_OFS, 32'h2);
        axi_write(pld_pkg::ALLOC0_OFS, 32'h88888848);
        pins.pulse_clk(0);
        read_chk("state alloc four", pld_pkg::STATE_OFS, 32'h0);
        axi_write(pld_pkg::ALLOC0_OFS, 32'h88888888);
        axi_write(pld_pkg::COMB_OFS, 32'h1);
        pins.pulse_clk(0);
        read_chk("state combined", pld_pkg::STATE_OFS, 32'h3);
        axi_write(pld_pkg::OSEL_OFS, 32'h1);
        settle();
        check("out combined sum", 32'h1, 32'(io_out[0]));
        axi_write(pld_pkg::COMB_OFS, 32'h0);
        settle();
        check("out sum term only", 32'h0, 32'(io_out[0]));
        axi_write(pld_pkg::OSEL_OFS, 32'h0);
    endtask
    task automatic t_preset_reset();
        set_term(210, 42'h4, NONE);
        set_term(180, 42'h2, NONE);
        pins.set_in(2, 1'b1);
        pins.pulse_clk(0);
        read_chk("state preset", pld_pkg::STATE_OFS, 32'h3);
        pins.set_in(1, 1'b1);
        settle();
        read_chk("state reset", pld_pkg::STATE_OFS, 32'h2);
        pins.pulse_clk(0);
        read_chk("reset over preset", pld_pkg::STATE_OFS, 32'h2);
        pins.set_in(1, 1'b0);
        pins.set_in(2, 1'b0);
    endtask
    task automatic t_preload();
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(pld_pkg::POL_OFS, 32'h1);
        pins.set_mode(1'b1, 1'b0);
        settle();
        check("oe_n preload", 32'h3ff, 32'(io_oe_n));
        read_chk("status preload", pld_pkg::STATUS_OFS, 32'h8);
        pins.set_io(10'h001);
        pins.pulse_clk(0);
        axi_read(pld_pkg::STATE_OFS, d, r);
        check("preload first", 32'h1, 32'(d[0]));
        pins.set_in(4, 1'b1);
        pins.set_io(10'h000);
        pins.pulse_clk(0);
        axi_read(pld_pkg::STATE_OFS, d, r);
        check("preload second", 32'h0, 32'(d[1]));
        pins.set_in(4, 1'b0);
        pins.set_mode(1'b0, 1'b0);
        pins.pulse_clk(0);
        read_chk("normal load", pld_pkg::STATE_OFS, 32'h2);
        axi_write(pld_pkg::POL_OFS, 32'h0);
    endtask
    task automatic t_fuse();
        logic [31:0] d;
        logic [1:0]  r;
        read_chk("pattern open", pld_pkg::PT_BASE, 32'hffffffff);
        pins.set_mode(1'b0, 1'b1);
        settle();
        check("oe_n verify", 32'h0, 32'(io_oe_n[0]));
        axi_write(pld_pkg::CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk);
        check("oe_n fused", 32'h3ff, 32'(io_oe_n));
        read_chk("status fused", pld_pkg::STATUS_OFS, 32'h6);
        read_chk("pattern hidden", pld_pkg::PT_BASE, 32'h0);
        axi_write(13'h0800, 32'h1, pld_pkg::RESP_SLVERR);
        axi_read(13'h0800, d, r);
        check("unmapped data", 32'h0, d);
        check("unmapped resp", 32'(pld_pkg::RESP_SLVERR), 32'(r));
    endtask

    initial
    begin
        rstn    = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = 13'h0000;
        araddr  = 13'h0000;
        wdata   = 32'h0;
        wstrb   = 4'h0;
        awprot  = 3'h0;
        arprot  = 3'h0;
        repeat (20) @(posedge clk);
        check("oe_n in reset", 32'h3ff, 32'(io_oe_n));
        check("out in reset", 32'h0, 32'(io_out));
        rstn <= 1'b1;
        t_power_up();
        t_clock_sum();
        t_comb_alloc();
        t_preset_reset();
        t_preload();
        t_fuse();
        tally_and_finish();
    end
endmodule // tb_top
